// file: core/wir_pkg.sv
// Package of constants, types and decode functions for the wake interrupt routing block.
package wir_pkg;

  // Management number ranges.
  localparam int MG_NMI_AO_LAST    = 15;
  localparam int MG_NMI_IO_LAST    = 31;
  localparam int MG_ASYNC_FIRST    = 32;
  localparam int MG_ASYNC_AO_LAST  = 95;
  localparam int MG_ASYNC_LAST     = 255;
  localparam int MG_SYNC_FIRST     = 256;
  localparam int MG_SYNC_LAST      = 512;

  // Management numbers of the individual sources.
  localparam int MG_LVD_FALL       = 16;
  localparam int MG_LVD_RISE       = 17;
  localparam int MG_WDT            = 18;
  localparam int MG_EXT_BASE       = 32;
  localparam int MG_I2C_WAKE       = 38;
  localparam int MG_USB_WAKE       = 39;
  localparam int MG_DMA_BASE       = 96;
  localparam int MG_SERIAL_RX0     = 256;
  localparam int MG_SPI_ERROR      = 262;
  localparam int MG_I2C0_ARB_LOST  = 264;

  // Source counts and positions in the controlled source vector.
  localparam int NUM_LVD_WDT       = 3;
  localparam int NUM_EXT           = 6;
  localparam int NUM_DMA           = 32;
  localparam int NUM_SYNC          = 20;
  localparam int IDX_EXT           = NUM_LVD_WDT;
  localparam int IDX_I2C_WAKE      = IDX_EXT + NUM_EXT;
  localparam int IDX_USB_WAKE      = IDX_I2C_WAKE + 1;
  localparam int IDX_DMA           = IDX_USB_WAKE + 1;
  localparam int NUM_CTL           = IDX_DMA + NUM_DMA;
  localparam int MON_WIDTH         = MG_ASYNC_LAST + 1;

  // Reset values.
  localparam logic RST_FLAG        = 1'b0;
  localparam logic RST_SYNC        = 1'b0;

  // Active level choices of a wake control register.
  typedef enum logic [2:0] {
    LVL_LOW,
    LVL_HIGH,
    LVL_RISE,
    LVL_FALL,
    LVL_BOTH
  } wir_level_e;

  // Power mode reported by the clock and mode controller.
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_FIRST_STOP,
    MODE_DEEP_STOP
  } wir_mode_e;

  // Wake control register of one source.
  typedef struct packed {
    logic       stopWakeEnable;
    wir_level_e level;
  } wir_ctl_s;

  // Management number of controlled source k.
  function automatic int srcMgmt(input int k);
    if (k < IDX_EXT) begin
      return MG_LVD_FALL + k;
    end else if (k < IDX_I2C_WAKE) begin
      return MG_EXT_BASE + (k - IDX_EXT);
    end else if (k == IDX_I2C_WAKE) begin
      return MG_I2C_WAKE;
    end else if (k == IDX_USB_WAKE) begin
      return MG_USB_WAKE;
    end
    return MG_DMA_BASE + (k - IDX_DMA);
  endfunction

  // A wake control register exists only below the synchronous range.
  function automatic logic mgmtHasCtl(input int mg);
    return (mg >= 0) && (mg <= MG_ASYNC_LAST);
  endfunction

  // Always-on bus holds the deep-stop register set.
  function automatic logic mgmtOnAlwaysOnBus(input int mg);
    return (mg <= MG_NMI_AO_LAST) || ((mg >= MG_ASYNC_FIRST) && (mg <= MG_ASYNC_AO_LAST));
  endfunction

endpackage

// file: core/wir_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module wir_sync
  import wir_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         nrst,
  // Asynchronous input and filtered result.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] stable
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] stable_next;

  // A change is taken once the second and third stages agree.
  always_comb begin
    stable_next = stable_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg     <= {W{RST_SYNC}};
      s2_reg     <= {W{RST_SYNC}};
      s3_reg     <= {W{RST_SYNC}};
      stable_reg <= {W{RST_SYNC}};
    end else begin
      s1_reg     <= din;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable = stable_reg;

endmodule // wir_sync
`default_nettype wire

// file: core/wake_interrupt_routing.sv
// Wake interrupt routing: conditions wake sources and forwards requests to the core.
`timescale 1ns/1ps
`default_nettype none

module wake_interrupt_routing
  import wir_pkg::*;
#(
  parameter int N_EXT  = NUM_EXT,
  parameter int N_DMA  = NUM_DMA,
  parameter int N_SYNC = NUM_SYNC
) (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Asynchronous wake capable sources.
  input  wire logic                   lvdFallIrq,
  input  wire logic                   lvdRiseIrq,
  input  wire logic                   watchdogIrq,
  input  wire logic [N_EXT-1:0]       extPinIrq,
  input  wire logic [N_EXT-1:0]       portInputEnable,
  input  wire logic                   i2cWakeIrq,
  input  wire logic                   usbWakeIrq,
  input  wire logic [N_DMA-1:0]       dmaChannelDoneIrq,
  // Synchronous sources on the system clock.
  input  wire logic [N_SYNC-1:0]      syncIrq,
  // Wake control registers and flag clear.
  input  wire wir_ctl_s               wakeCtl [NUM_CTL],
  input  wire logic [NUM_CTL-1:0]     flagClear,
  input  wire logic [NUM_CTL-1:0]     coreIrqSetEnable,
  // Power mode status.
  input  wire wir_mode_e              powerMode,
  input  wire logic                   fastOscStable,
  // Requests to the core.
  output logic [NUM_CTL-1:0]          coreIrqAsync,
  output logic [N_SYNC-1:0]           coreIrqSync,
  // Monitor flags and wake status.
  output logic [MON_WIDTH-1:0]        monitorFlags,
  output logic                        wakeRequest,
  output logic                        coreResume
);

  localparam int MAP_LVD_FALL = MG_LVD_FALL;
  localparam int MAP_LVD_RISE = MG_LVD_RISE;
  localparam int MAP_WDT      = MG_WDT;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_OSC_WAIT
  } wir_state_e;

  logic [NUM_CTL-1:0]   rawAsync;
  logic [NUM_CTL-1:0]   srcLevel;
  logic [NUM_CTL-1:0]   srcPrev_reg;
  logic [NUM_CTL-1:0]   detect;
  logic [NUM_CTL-1:0]   wakeEn;
  logic [NUM_CTL-1:0]   deepSet;
  logic [NUM_CTL-1:0]   flag_reg;
  logic [NUM_CTL-1:0]   flag_next;
  logic [NUM_CTL-1:0]   coreAsync_reg;
  logic [NUM_CTL-1:0]   coreAsync_next;
  logic [N_SYNC-1:0]    coreSync_reg;
  logic [MON_WIDTH-1:0] mon_reg;
  logic [MON_WIDTH-1:0] mon_next;
  logic [N_EXT-1:0]     extGated;
  logic                 wakeHit;
  wir_state_e           state_reg;
  wir_state_e           state_next;
  logic                 wakeReq_reg;
  logic                 wakeReq_next;
  logic                 resume_reg;
  logic                 resume_next;

  // A pin whose input buffer is disabled reads high.
  always_comb begin
    for (int i = 0; i < N_EXT; i++) begin
      extGated[i] = portInputEnable[i] ? extPinIrq[i] : 1'b1;
    end
  end

  // Source vector in controlled-source order; the position fixes the management number.
  always_comb begin
    rawAsync = '0;
    rawAsync[MAP_LVD_FALL - MG_LVD_FALL] = lvdFallIrq;
    rawAsync[MAP_LVD_RISE - MG_LVD_FALL] = lvdRiseIrq;
    rawAsync[MAP_WDT - MG_LVD_FALL]      = watchdogIrq;
    rawAsync[IDX_EXT +: N_EXT]           = extGated;
    rawAsync[IDX_I2C_WAKE]               = i2cWakeIrq;
    rawAsync[IDX_USB_WAKE]               = usbWakeIrq;
    rawAsync[IDX_DMA +: N_DMA]           = dmaChannelDoneIrq;
  end

  wir_sync #(
    .W      (NUM_CTL)
  ) u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .din    (rawAsync),
    .stable (srcLevel)
  );

  // Register set and control presence derived from the management number.
  generate
    for (genvar k = 0; k < NUM_CTL; k++) begin : g_dec
      assign deepSet[k] = mgmtOnAlwaysOnBus(srcMgmt(k));
      assign wakeEn[k]  = mgmtHasCtl(srcMgmt(k)) & wakeCtl[k].stopWakeEnable;
    end
  endgenerate

  // Edge or level detection chosen per source.
  always_comb begin
    detect = '0;
    for (int k = 0; k < NUM_CTL; k++) begin
      unique case (wakeCtl[k].level)
        LVL_LOW:  detect[k] = ~srcLevel[k];
        LVL_HIGH: detect[k] = srcLevel[k];
        LVL_RISE: detect[k] = srcLevel[k] & ~srcPrev_reg[k];
        LVL_FALL: detect[k] = ~srcLevel[k] & srcPrev_reg[k];
        LVL_BOTH: detect[k] = srcLevel[k] ^ srcPrev_reg[k];
        default:  detect[k] = 1'b0;
      endcase
    end
  end

  // Sticky flags; a detection in the clear cycle wins over the clear.
  always_comb begin
    flag_next = '0;
    for (int k = 0; k < NUM_CTL; k++) begin
      flag_next[k] = (wakeEn[k] & detect[k]) | (flag_reg[k] & ~flagClear[k]);
    end
  end

  // Wake sources reach the core through their flag, the rest pass straight on.
  always_comb begin
    coreAsync_next = '0;
    for (int k = 0; k < NUM_CTL; k++) begin
      coreAsync_next[k] = wakeEn[k] ? flag_next[k] : srcLevel[k];
    end
  end

  // Monitor flags placed at their management number.
  always_comb begin
    mon_next = '0;
    for (int k = 0; k < NUM_CTL; k++) begin
      mon_next[srcMgmt(k)] = flag_next[k];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srcPrev_reg   <= '0;
      flag_reg      <= {NUM_CTL{RST_FLAG}};
      coreAsync_reg <= '0;
      coreSync_reg  <= '0;
      mon_reg       <= '0;
    end else begin
      srcPrev_reg   <= srcLevel;
      flag_reg      <= flag_next;
      coreAsync_reg <= coreAsync_next;
      coreSync_reg  <= syncIrq;
      mon_reg       <= mon_next;
    end
  end

  // A flag may release the current mode only with the core enable set and the matching register set.
  always_comb begin
    wakeHit = 1'b0;
    for (int k = 0; k < NUM_CTL; k++) begin
      if (flag_reg[k] && wakeEn[k] && coreIrqSetEnable[k]) begin
        if ((powerMode != MODE_DEEP_STOP) || deepSet[k]) begin
          wakeHit = 1'b1;
        end
      end
    end
  end

  // Wake sequencing: stop modes wait for the fast oscillator before resuming.
  always_comb begin
    state_next   = state_reg;
    wakeReq_next = wakeReq_reg;
    resume_next  = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        if (powerMode != MODE_NORMAL) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (powerMode == MODE_NORMAL) begin
          state_next = ST_RUN;
        end else if (wakeHit) begin
          wakeReq_next = 1'b1;
          if (powerMode == MODE_IDLE) begin
            state_next   = ST_RUN;
            wakeReq_next = 1'b0;
            resume_next  = 1'b1;
          end else begin
            state_next = ST_OSC_WAIT;
          end
        end
      end
      ST_OSC_WAIT: begin
        if (fastOscStable) begin
          state_next   = ST_RUN;
          wakeReq_next = 1'b0;
          resume_next  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_RUN;
      wakeReq_reg <= 1'b0;
      resume_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      wakeReq_reg <= wakeReq_next;
      resume_reg  <= resume_next;
    end
  end

  assign coreIrqAsync = coreAsync_reg;
  assign coreIrqSync  = coreSync_reg;
  assign monitorFlags = mon_reg;
  assign wakeRequest  = wakeReq_reg;
  assign coreResume   = resume_reg;

endmodule // wake_interrupt_routing
`default_nettype wire

// file: bench/wir_checker_sva.sv
// Concurrent checks on the ports of the wake interrupt routing block.
`timescale 1ns/1ps
`default_nettype none
module wir_checker
  import wir_pkg::*;
#(
  parameter int N_SYNC = NUM_SYNC
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic [N_SYNC-1:0]    syncIrq,
  input wire logic [NUM_CTL-1:0]   flagClear,
  input wire wir_mode_e            powerMode,
  input wire logic                 fastOscStable,
  input wire logic [NUM_CTL-1:0]   coreIrqAsync,
  input wire logic [N_SYNC-1:0]    coreIrqSync,
  input wire logic [MON_WIDTH-1:0] monitorFlags,
  input wire logic                 wakeRequest,
  input wire logic                 coreResume
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SYNC_DIRECT: assert property (nrst && $past(nrst) |-> coreIrqSync == $past(syncIrq))
    else $error("sync request not forwarded");
  AST_MON_UNUSED: assert property (monitorFlags[15:0] == 0 && monitorFlags[31:19] == 0 &&
    monitorFlags[95:40] == 0 && monitorFlags[255:128] == 0) else $error("unused monitor bit set");
  AST_FLAG_SHOWN: assert property ((monitorFlags[18:16] & ~coreIrqAsync[2:0]) == 0 &&
    (monitorFlags[39:32] & ~coreIrqAsync[10:3]) == 0 && (monitorFlags[127:96] & ~coreIrqAsync[42:11]) == 0)
    else $error("flag set but core request low");
  AST_FLAG_STICKY: assert property (nrst && $past(nrst) |->
    ($past(monitorFlags[39:32]) & ~$past(flagClear[10:3]) & ~monitorFlags[39:32]) == 8'h00)
    else $error("flag lost without clear");
  AST_WAKE_MODE: assert property ($rose(wakeRequest) |-> $past(powerMode) inside {MODE_FIRST_STOP, MODE_DEEP_STOP})
    else $error("wake request outside stop");
  AST_RESUME_AFTER_OSC: assert property (coreResume && $past(wakeRequest) |-> $past(fastOscStable))
    else $error("resume before oscillator stable");
  AST_OSC_ENDS_WAIT: assert property (wakeRequest && fastOscStable |=> !wakeRequest && coreResume)
    else $error("no resume after oscillator stable");
  AST_RESUME_PULSE: assert property (coreResume |=> !coreResume)
    else $error("resume longer than one cycle");
  AST_WAKE_HOLD: assert property (wakeRequest && !fastOscStable |=> wakeRequest)
    else $error("wake request dropped early");
  cover property (coreResume && $past(wakeRequest));
  cover property ($rose(wakeRequest) && powerMode == MODE_DEEP_STOP);
  cover property (coreResume && !$past(wakeRequest));
endmodule // wir_checker
`default_nettype wire

// file: bench/wir_core_model.sv
// Core side model: fast oscillator start-up after a stop wake.
`timescale 1ns/1ps
`default_nettype none
module wir_core_model #(
  parameter int OSC_DLY = 3
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic wakeRequest,
  output logic      fastOscStable
);
  int oscCnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oscCnt <= 0;
    end else begin
      oscCnt <= wakeRequest ? oscCnt + 1 : 0;
    end
  end
  assign fastOscStable = wakeRequest && (oscCnt >= OSC_DLY);
endmodule // wir_core_model
`default_nettype wire

// file: bench/wake_interrupt_routing_tb.sv
// Self-checking bench for the wake interrupt routing block.
`timescale 1ns/1ps
`default_nettype none
module wake_interrupt_routing_tb;
  import wir_pkg::*;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 lvdFallIrq, lvdRiseIrq, watchdogIrq, i2cWakeIrq, usbWakeIrq, fastOscStable;
  logic [NUM_EXT-1:0]   extPinIrq, portInputEnable;
  logic [NUM_DMA-1:0]   dmaChannelDoneIrq;
  logic [NUM_SYNC-1:0]  syncIrq, coreIrqSync;
  logic [NUM_CTL-1:0]   flagClear, coreIrqSetEnable, coreIrqAsync;
  logic [MON_WIDTH-1:0] monitorFlags;
  logic                 wakeRequest, coreResume;
  wir_ctl_s             wakeCtl [NUM_CTL];
  wir_mode_e            powerMode;
  int                   errCount = 0, nTests = 0, cycles = 0;
  localparam logic [3:0] LVL_EXP [5] = '{4'hB, 4'hE, 4'h2, 4'h8, 4'hA};
  localparam wir_mode_e  WM [7] = '{MODE_FIRST_STOP, MODE_DEEP_STOP, MODE_DEEP_STOP, MODE_DEEP_STOP,
                                   MODE_FIRST_STOP, MODE_DEEP_STOP, MODE_IDLE};
  localparam int         WK [7] = '{5, 0, 5, 5, 17, 17, 0};
  localparam logic [6:0] WSE = 7'h7B;
  localparam logic [6:0] WEXP = 7'h59;

  always #12.5 clk = ~clk;

  wake_interrupt_routing u_dut (.clk, .nrst, .lvdFallIrq, .lvdRiseIrq, .watchdogIrq, .extPinIrq,
    .portInputEnable, .i2cWakeIrq, .usbWakeIrq, .dmaChannelDoneIrq, .syncIrq, .wakeCtl, .flagClear,
    .coreIrqSetEnable, .powerMode, .fastOscStable, .coreIrqAsync, .coreIrqSync, .monitorFlags,
    .wakeRequest, .coreResume);
  wir_core_model #(.OSC_DLY(3)) u_core (.clk, .nrst, .wakeRequest, .fastOscStable);

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic after(input int n);
    tick(n);
    @(negedge clk);
  endtask
  task automatic reportAndStop();
    $display("comparisons=%0d mismatches=%0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic clearFlag(input int k);
    flagClear[k] <= 1'b1;
    tick(1);
    flagClear[k] <= 1'b0;
    tick(1);
  endtask
  task automatic setSrc(input int k, input logic v);
    case (k)
      0: lvdFallIrq <= v;
      5: extPinIrq[2] <= v;
      default: dmaChannelDoneIrq[k-11] <= v;
    endcase
  endtask
  task automatic chkPin(input logic e);
    check({monitorFlags[32], coreIrqAsync[3]}, {e, e});
  endtask

  task automatic testDirect();
    syncIrq <= 20'h00141;
    after(2);
    check(coreIrqSync, 20'h00141);
    tick(1);
    syncIrq <= '0;
    after(2);
    check(coreIrqSync, 20'h00000);
    tick(1);
  endtask
  task automatic testNonWake();
    extPinIrq[1] <= 1'b1;
    after(7);
    check({coreIrqAsync[4], monitorFlags[33]}, 2'b10);
    tick(1);
    extPinIrq[1] <= 1'b0;
    portInputEnable[1] <= 1'b0;
    after(7);
    check(coreIrqAsync[4], 1'b1);
    tick(1);
    portInputEnable[1] <= 1'b1;
    after(7);
    check(coreIrqAsync[4], 1'b0);
    tick(1);
  endtask
  task automatic testLevels();
    for (int l = 0; l < 5; l++) begin
      wakeCtl[3] <= '{1'b1, wir_level_e'(l)};
      extPinIrq[0] <= 1'b0;
      tick(8);
      clearFlag(3);
      after(1);
      chkPin(LVL_EXP[l][0]);
      tick(1);
      extPinIrq[0] <= 1'b1;
      after(7);
      chkPin(LVL_EXP[l][1]);
      tick(1);
      clearFlag(3);
      after(1);
      chkPin(LVL_EXP[l][2]);
      tick(1);
      extPinIrq[0] <= 1'b0;
      after(7);
      chkPin(LVL_EXP[l][3]);
      tick(1);
    end
    wakeCtl[3] <= '{1'b0, LVL_HIGH};
    clearFlag(3);
    after(6);
    chkPin(1'b0);
    tick(1);
  endtask
  task automatic testMap();
    wakeCtl[0] <= '{1'b1, LVL_HIGH};
    wakeCtl[1] <= '{1'b1, LVL_HIGH};
    wakeCtl[2] <= '{1'b1, LVL_HIGH};
    wakeCtl[17] <= '{1'b1, LVL_RISE};
    wakeCtl[36] <= '{1'b1, LVL_RISE};
    {lvdFallIrq, lvdRiseIrq, watchdogIrq} <= 3'h7;
    dmaChannelDoneIrq <= 32'h02000040;
    after(7);
    check(monitorFlags[18:16], 3'h7);
    check({monitorFlags[121], monitorFlags[102], monitorFlags[101]}, 3'h6);
    tick(1);
    for (int k = 0; k < NUM_CTL; k++) begin
      wakeCtl[k] <= '{1'b0, LVL_HIGH};
    end
    {lvdFallIrq, lvdRiseIrq, watchdogIrq} <= 3'h0;
    dmaChannelDoneIrq <= '0;
    flagClear <= '1;
    tick(1);
    flagClear <= '0;
    tick(7);
  endtask
  task automatic testWake();
    logic got;
    logic req;
    for (int i = 0; i < 7; i++) begin
      got = 1'b0;
      req = 1'b0;
      wakeCtl[WK[i]] <= '{1'b1, LVL_RISE};
      coreIrqSetEnable[WK[i]] <= WSE[i];
      tick(2);
      clearFlag(WK[i]);
      powerMode <= WM[i];
      tick(3);
      setSrc(WK[i], 1'b1);
      repeat (30) begin
        @(negedge clk);
        got = got | (coreResume === 1'b1);
        req = req | (wakeRequest === 1'b1);
      end
      check(got, WEXP[i]);
      check(req, WEXP[i] && WM[i] != MODE_IDLE);
      tick(1);
      powerMode <= MODE_NORMAL;
      setSrc(WK[i], 1'b0);
      wakeCtl[WK[i]] <= '{1'b0, LVL_RISE};
      coreIrqSetEnable[WK[i]] <= 1'b0;
      clearFlag(WK[i]);
      tick(6);
    end
  endtask

  initial begin
    {lvdFallIrq, lvdRiseIrq, watchdogIrq, i2cWakeIrq, usbWakeIrq} = '0;
    extPinIrq = '0;
    portInputEnable = '1;
    dmaChannelDoneIrq = '0;
    syncIrq = '0;
    flagClear = '0;
    coreIrqSetEnable = '0;
    powerMode = MODE_NORMAL;
    for (int k = 0; k < NUM_CTL; k++) begin
      wakeCtl[k] = '{1'b0, LVL_HIGH};
    end
    tick(16);
    nrst <= 1'b1;
    tick(2);
    testDirect();
    testNonWake();
    testLevels();
    testMap();
    testWake();
    reportAndStop();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      reportAndStop();
    end
  end
endmodule // wake_interrupt_routing_tb
bind wake_interrupt_routing wir_checker #(.N_SYNC(N_SYNC)) u_chk (.clk, .nrst, .syncIrq, .flagClear,
  .powerMode, .fastOscStable, .coreIrqAsync, .coreIrqSync, .monitorFlags, .wakeRequest, .coreResume);
`default_nettype wire
